/* design/bbx_pkg.sv */
// Constants and types of the branch and bit instruction execution block.
// Assumes a 32-bit Avalon-MM register bus and an 8-bit status flag register.
package bbx_pkg;

  // ***********************************************************************
  // Register byte offsets
  // ***********************************************************************
  localparam logic [5:0] off_insn    = 6'h00;
  localparam logic [5:0] off_operand = 6'h04;
  localparam logic [5:0] off_pc      = 6'h08;
  localparam logic [5:0] off_zptr    = 6'h0C;
  localparam logic [5:0] off_sp      = 6'h10;
  localparam logic [5:0] off_status_flags_register    = 6'h14;
  localparam logic [5:0] off_result  = 6'h18;
  localparam logic [5:0] off_status  = 6'h1C;
  localparam logic [5:0] off_retaddr = 6'h20;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int insn_op_lsb   = 0;
  localparam int insn_sel_lsb  = 5;
  localparam int insn_k_lsb    = 8;
  localparam int insn_imm_lsb  = 16;
  localparam int opnd_dst_lsb  = 0;
  localparam int opnd_src_lsb  = 8;
  localparam int opnd_io_lsb   = 16;
  localparam int opnd_two_bit  = 24;
  localparam int res_we_bit    = 8;
  localparam int stat_busy_bit = 0;
  localparam int stat_cyc_lsb  = 4;
  localparam int stat_tak_bit  = 8;

  // ***********************************************************************
  // Status flag bit positions
  // ***********************************************************************
  localparam logic [2:0] flag_c = 3'h0;
  localparam logic [2:0] flag_z = 3'h1;
  localparam logic [2:0] flag_n = 3'h2;
  localparam logic [2:0] flag_v = 3'h3;
  localparam logic [2:0] flag_s = 3'h4;
  localparam logic [2:0] flag_h = 3'h5;
  localparam logic [2:0] flag_t = 3'h6;
  localparam logic [2:0] flag_i = 3'h7;

  // ***********************************************************************
  // Reset values and timing counts
  // ***********************************************************************
  localparam logic [15:0] pc_reset   = 16'h0000;
  localparam logic [15:0] zptr_reset = 16'h0000;
  localparam logic [15:0] sp_reset   = 16'hFFFF;
  localparam logic [7:0]  status_flags_register_reset = 8'h00;
  localparam logic [1:0]  cyc_one    = 2'h1;
  localparam logic [1:0]  cyc_two    = 2'h2;
  localparam logic [1:0]  cyc_three  = 2'h3;
  localparam logic [15:0] ret_push   = 16'h0002;

  // ***********************************************************************
  // Operations and states
  // ***********************************************************************
  typedef enum logic [4:0] {
    op_pointer_jump        = 5'h00,
    op_pointer_call        = 5'h01,
    op_compare_skip_equal  = 5'h02,
    op_compare_immediate   = 5'h03,
    op_skip_reg_bit_clear  = 5'h04,
    op_skip_reg_bit_set    = 5'h05,
    op_skip_io_bit_clear   = 5'h06,
    op_skip_io_bit_set     = 5'h07,
    op_branch_flag_set     = 5'h08,
    op_branch_flag_clear   = 5'h09,
    op_branch_signed_ge    = 5'h0A,
    op_branch_signed_lt    = 5'h0B,
    op_rotate_left_carry   = 5'h0C,
    op_rotate_right_carry  = 5'h0D,
    op_bit_to_transfer     = 5'h0E,
    op_transfer_to_bit     = 5'h0F,
    op_flag_on             = 5'h10,
    op_flag_off            = 5'h11
  } bbx_op_t;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_exec = 1'b1
  } bbx_state_t;

endpackage : bbx_pkg

/* design/bbx_exec_if.sv */
// Interface between the sequencer and the condition and flag unit.
// Assumes both ends sit in the same clock domain; all signals combinational.
`timescale 1ns/10ps
interface bbx_exec_if;
  bbx_pkg::bbx_op_t op;
  logic [2:0]       sel;
  logic [7:0]       imm;
  logic [7:0]       dst;
  logic [7:0]       src;
  logic [7:0]       io;
  logic             two_word;
  logic [7:0]       status_flags_register;
  logic             taken;
  logic [7:0]       status_flags_register_new;
  logic [7:0]       result;
  logic             result_we;
  logic [1:0]       cycles;

  modport core (output op, sel, imm, dst, src, io, two_word, status_flags_register,
                input  taken, status_flags_register_new, result, result_we, cycles);
  modport unit (input  op, sel, imm, dst, src, io, two_word, status_flags_register,
                output taken, status_flags_register_new, result, result_we, cycles);
endinterface : bbx_exec_if

/* design/bbx_cond_unit.sv */
// Condition, flag and cycle-count evaluation for one instruction.
// Assumes operands on the interface are stable while the instruction executes.
`timescale 1ns/10ps
module bbx_cond_unit (
  bbx_exec_if.unit x
);

  logic [8:0] diff;
  logic [7:0] rot;

  always_comb
  begin
    diff        = {1'b0, x.dst} - {1'b0, x.imm};
    rot         = 8'h00;
    x.taken     = 1'b0;
    x.status_flags_register_new  = x.status_flags_register;
    x.result    = x.dst;
    x.result_we = 1'b0;
    x.cycles    = bbx_pkg::cyc_one;
    case (x.op)
      bbx_pkg::op_pointer_jump:
        x.cycles = bbx_pkg::cyc_two;
      bbx_pkg::op_pointer_call:
        x.cycles = bbx_pkg::cyc_three;
      bbx_pkg::op_compare_skip_equal:
        x.taken = (x.dst == x.src);
      bbx_pkg::op_skip_reg_bit_clear:
        x.taken = ~x.dst[x.sel];
      bbx_pkg::op_skip_reg_bit_set:
        x.taken = x.dst[x.sel];
      bbx_pkg::op_skip_io_bit_clear:
        x.taken = ~x.io[x.sel];
      bbx_pkg::op_skip_io_bit_set:
        x.taken = x.io[x.sel];
      bbx_pkg::op_branch_flag_set:
        x.taken = x.status_flags_register[x.sel];
      bbx_pkg::op_branch_flag_clear:
        x.taken = ~x.status_flags_register[x.sel];
      bbx_pkg::op_branch_signed_ge:
        x.taken = ~(x.status_flags_register[bbx_pkg::flag_n] ^ x.status_flags_register[bbx_pkg::flag_v]);
      bbx_pkg::op_branch_signed_lt:
        x.taken = x.status_flags_register[bbx_pkg::flag_n] ^ x.status_flags_register[bbx_pkg::flag_v];
      bbx_pkg::op_compare_immediate:
      begin
        x.status_flags_register_new[bbx_pkg::flag_c] = diff[8];
        x.status_flags_register_new[bbx_pkg::flag_z] = (diff[7:0] == 8'h00);
        x.status_flags_register_new[bbx_pkg::flag_n] = diff[7];
        x.status_flags_register_new[bbx_pkg::flag_v] = (x.dst[7] & ~x.imm[7] & ~diff[7]) | (~x.dst[7] & x.imm[7] & diff[7]);
        x.status_flags_register_new[bbx_pkg::flag_h] = (~x.dst[3] & x.imm[3]) | (x.imm[3] & diff[3]) | (diff[3] & ~x.dst[3]);
      end
      bbx_pkg::op_rotate_left_carry, bbx_pkg::op_rotate_right_carry:
      begin
        if (x.op == bbx_pkg::op_rotate_left_carry)
        begin
          rot                         = {x.dst[6:0], x.status_flags_register[bbx_pkg::flag_c]};
          x.status_flags_register_new[bbx_pkg::flag_c] = x.dst[7];
        end
        else
        begin
          rot                         = {x.status_flags_register[bbx_pkg::flag_c], x.dst[7:1]};
          x.status_flags_register_new[bbx_pkg::flag_c] = x.dst[0];
        end
        x.result                    = rot;
        x.result_we                 = 1'b1;
        x.status_flags_register_new[bbx_pkg::flag_z] = (rot == 8'h00);
        x.status_flags_register_new[bbx_pkg::flag_n] = rot[7];
        x.status_flags_register_new[bbx_pkg::flag_v] = rot[7] ^ x.status_flags_register_new[bbx_pkg::flag_c];
      end
      bbx_pkg::op_bit_to_transfer:
        x.status_flags_register_new[bbx_pkg::flag_t] = x.dst[x.sel];
      bbx_pkg::op_transfer_to_bit:
      begin
        x.result[x.sel] = x.status_flags_register[bbx_pkg::flag_t];
        x.result_we     = 1'b1;
      end
      bbx_pkg::op_flag_on:
        x.status_flags_register_new[x.sel] = 1'b1;
      bbx_pkg::op_flag_off:
        x.status_flags_register_new[x.sel] = 1'b0;
      default:
        x.taken = 1'b0;
    endcase
    // Skips cost one extra cycle per skipped word, branches one when taken
    if (x.op inside {bbx_pkg::op_compare_skip_equal, bbx_pkg::op_skip_reg_bit_clear,
                     bbx_pkg::op_skip_reg_bit_set, bbx_pkg::op_skip_io_bit_clear,
                     bbx_pkg::op_skip_io_bit_set} && x.taken)
      x.cycles = x.two_word ? bbx_pkg::cyc_three : bbx_pkg::cyc_two;
    else if (x.op inside {bbx_pkg::op_branch_flag_set, bbx_pkg::op_branch_flag_clear,
                          bbx_pkg::op_branch_signed_ge, bbx_pkg::op_branch_signed_lt} && x.taken)
      x.cycles = bbx_pkg::cyc_two;
  end

endmodule : bbx_cond_unit

/* design/bbx_exec_top.sv */
// Branch, skip and bit instruction execution block with Avalon-MM registers.
// Assumes one 40 MHz clock; stack memory and register file sit outside.
//
// Function
// - Pointer jump loads the program counter from Z, no flags, 2 cycles.
// - Pointer call pushes return address, loads PC from Z, 3 cycles.
// - Compare-skip-equal skips next instruction on equal operands, 1/2/3 cycles.
// - Compare-immediate sets Z, N, V, C, H from register minus constant.
// - Skip on register bit clear, 1/2/3 cycles, flags untouched.
// - Skip on register bit set, 1/2/3 cycles, flags untouched.
// - Skip on I/O bit clear, 1/2/3 cycles.
// - Skip on I/O bit set, 1/2/3 cycles.
// - Branch when selected flag set: PC plus k plus 1, 1/2 cycles.
// - Branch when selected flag clear: PC plus k plus 1, 1/2 cycles.
// - Carry branches: clear and same-or-higher on C=0, set and lower on C=1.
// - Signed greater-or-equal branch taken when N xor V is 0.
// - Signed less-than branch taken when N xor V is 1.
// - Half-carry branches test H set or clear, 1/2 cycles.
// - Transfer-bit and overflow branches test T or V, 1/2 cycles.
// - Interrupt-state branches test the global enable bit, 1/2 cycles.
// - Rotate left through carry, updates Z, C, N, V in 1 cycle.
// - Rotate right through carry, updates Z, C, N, V in 1 cycle.
// - Bit store copies register bit into T only, 1 cycle.
// - Bit load copies T into register bit, no flags, 1 cycle.
// - Flag set or clear changes exactly one status flag in 1 cycle.
`timescale 1ns/10ps
module bbx_exec_top (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Status
  output logic             busy_o
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  bbx_pkg::bbx_state_t state;
  bbx_pkg::bbx_state_t next_state;
  logic [31:0]         insn;
  logic [31:0]         operand;
  logic [15:0]         pc;
  logic [15:0]         zptr;
  logic [15:0]         sp;
  logic [7:0]          status_flags_register;
  logic [7:0]          result;
  logic                result_written;
  logic [15:0]         retaddr;
  logic [1:0]          elapsed;
  logic [1:0]          last_cycles;
  logic                last_taken;
  logic [15:0]         next_pc;
  logic [31:0]         next_readdata;
  logic                wr_ok;
  logic                rd_ok;
  logic                finish;
  logic [15:0]         k_ext;
  logic [31:0]         pc_merged;
  logic [31:0]         sp_merged;
  logic [31:0]         zptr_merged;
  logic [31:0]         status_flags_register_merged;

  bbx_exec_if x ();

  // ***********************************************************************
  // Byte-lane merge
  // ***********************************************************************
  function automatic logic [31:0] bbx_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        m[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return m;
  endfunction : bbx_merge

  // Narrow registers merged as full words, low bits kept
  assign pc_merged   = bbx_merge({16'h0000, pc}, avs_writedata_i, avs_byteenable_i);
  assign sp_merged   = bbx_merge({16'h0000, sp}, avs_writedata_i, avs_byteenable_i);
  assign zptr_merged = bbx_merge({16'h0000, zptr}, avs_writedata_i, avs_byteenable_i);
  assign status_flags_register_merged = bbx_merge({24'h00_0000, status_flags_register}, avs_writedata_i, avs_byteenable_i);

  // ***********************************************************************
  // Condition and flag unit
  // ***********************************************************************
  assign x.op       = bbx_pkg::bbx_op_t'(insn[bbx_pkg::insn_op_lsb +: 5]);
  assign x.sel      = insn[bbx_pkg::insn_sel_lsb +: 3];
  assign x.imm      = insn[bbx_pkg::insn_imm_lsb +: 8];
  assign x.dst      = operand[bbx_pkg::opnd_dst_lsb +: 8];
  assign x.src      = operand[bbx_pkg::opnd_src_lsb +: 8];
  assign x.io       = operand[bbx_pkg::opnd_io_lsb +: 8];
  assign x.two_word = operand[bbx_pkg::opnd_two_bit];
  assign x.status_flags_register     = status_flags_register;

  bbx_cond_unit u_cond (
    .x (x.unit)
  );

  // ***********************************************************************
  // Bus handshake
  // ***********************************************************************
  // Writes stall while an instruction runs so operands stay stable
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_waitrequest_o <= 1'b1;
    else if (avs_waitrequest_o && (avs_read_i || (avs_write_i && state == bbx_pkg::st_idle)))
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign rd_ok = avs_read_i && avs_waitrequest_o;

  // ***********************************************************************
  // Read data
  // ***********************************************************************
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address_i)
      bbx_pkg::off_insn:    next_readdata = insn;
      bbx_pkg::off_operand: next_readdata = operand;
      bbx_pkg::off_pc:      next_readdata = {16'h0000, pc};
      bbx_pkg::off_zptr:    next_readdata = {16'h0000, zptr};
      bbx_pkg::off_sp:      next_readdata = {16'h0000, sp};
      bbx_pkg::off_status_flags_register:    next_readdata = {24'h00_0000, status_flags_register};
      bbx_pkg::off_result:
      begin
        next_readdata[7:0]                  = result;
        next_readdata[bbx_pkg::res_we_bit]  = result_written;
      end
      bbx_pkg::off_status:
      begin
        next_readdata[bbx_pkg::stat_busy_bit]     = (state == bbx_pkg::st_exec);
        next_readdata[bbx_pkg::stat_cyc_lsb +: 2] = last_cycles;
        next_readdata[bbx_pkg::stat_tak_bit]      = last_taken;
      end
      bbx_pkg::off_retaddr: next_readdata = {16'h0000, retaddr};
      default:              next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (rd_ok)
      avs_readdata_o <= next_readdata;
  end

  // ***********************************************************************
  // Sequencer
  // ***********************************************************************
  // Busy for exactly the instruction's cycle count, then commit
  assign finish = (state == bbx_pkg::st_exec) && ((elapsed + 2'h1) == x.cycles);

  always_comb
  begin
    next_state = state;
    case (state)
      bbx_pkg::st_idle:
        if (wr_ok && avs_address_i == bbx_pkg::off_insn)
          next_state = bbx_pkg::st_exec;
      bbx_pkg::st_exec:
        if (finish)
          next_state = bbx_pkg::st_idle;
      default:
        next_state = bbx_pkg::st_idle;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= bbx_pkg::st_idle;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      elapsed <= 2'h0;
    else if (state == bbx_pkg::st_exec && !finish)
      elapsed <= elapsed + 2'h1;
    else
      elapsed <= 2'h0;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      busy_o <= 1'b0;
    else
      busy_o <= (next_state == bbx_pkg::st_exec);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      last_cycles <= 2'h0;
      last_taken  <= 1'b0;
    end
    else if (finish)
    begin
      last_cycles <= x.cycles;
      last_taken  <= x.taken;
    end
  end

  // ***********************************************************************
  // Program counter
  // ***********************************************************************
  assign k_ext = {{9{insn[bbx_pkg::insn_k_lsb + 6]}}, insn[bbx_pkg::insn_k_lsb +: 7]};

  always_comb
  begin
    next_pc = pc + 16'h0001;
    case (x.op)
      bbx_pkg::op_pointer_jump, bbx_pkg::op_pointer_call:
        next_pc = zptr;
      bbx_pkg::op_compare_skip_equal, bbx_pkg::op_skip_reg_bit_clear, bbx_pkg::op_skip_reg_bit_set,
      bbx_pkg::op_skip_io_bit_clear, bbx_pkg::op_skip_io_bit_set:
        if (x.taken)
          next_pc = x.two_word ? pc + 16'h0003 : pc + 16'h0002;
      bbx_pkg::op_branch_flag_set, bbx_pkg::op_branch_flag_clear,
      bbx_pkg::op_branch_signed_ge, bbx_pkg::op_branch_signed_lt:
        if (x.taken)
          next_pc = pc + k_ext + 16'h0001;
      default:
        next_pc = pc + 16'h0001;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      pc <= bbx_pkg::pc_reset;
    else if (finish)
      pc <= next_pc;
    else if (wr_ok && avs_address_i == bbx_pkg::off_pc)
      pc <= pc_merged[15:0];
  end

  // ***********************************************************************
  // Call return address and stack pointer
  // ***********************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      retaddr <= 16'h0000;
    else if (finish && x.op == bbx_pkg::op_pointer_call)
      retaddr <= pc + 16'h0001;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      sp <= bbx_pkg::sp_reset;
    else if (finish && x.op == bbx_pkg::op_pointer_call)
      sp <= sp - bbx_pkg::ret_push;
    else if (wr_ok && avs_address_i == bbx_pkg::off_sp)
      sp <= sp_merged[15:0];
  end

  // ***********************************************************************
  // Software-loaded registers
  // ***********************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      insn <= 32'h0000_0000;
    else if (wr_ok && avs_address_i == bbx_pkg::off_insn)
      insn <= bbx_merge(insn, avs_writedata_i, avs_byteenable_i);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      operand <= 32'h0000_0000;
    else if (wr_ok && avs_address_i == bbx_pkg::off_operand)
      operand <= bbx_merge(operand, avs_writedata_i, avs_byteenable_i);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      zptr <= bbx_pkg::zptr_reset;
    else if (wr_ok && avs_address_i == bbx_pkg::off_zptr)
      zptr <= zptr_merged[15:0];
  end

  // ***********************************************************************
  // Status flags
  // ***********************************************************************
  // Branches, skips, jumps and calls return the flags unchanged
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      status_flags_register <= bbx_pkg::status_flags_register_reset;
    else if (finish)
      status_flags_register <= x.status_flags_register_new;
    else if (wr_ok && avs_address_i == bbx_pkg::off_status_flags_register)
      status_flags_register <= status_flags_register_merged[7:0];
  end

  // ***********************************************************************
  // Register write-back
  // ***********************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result         <= 8'h00;
      result_written <= 1'b0;
    end
    else if (finish)
    begin
      result         <= x.result;
      result_written <= x.result_we;
    end
  end

endmodule : bbx_exec_top

/* test/bbx_exec_properties.sv */
// Bus and cycle-count properties of the execution block.
// Assumes binding to bbx_exec_top; sees its ports only.
`timescale 1ns/10ps
module bbx_exec_chk (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // Bus and status
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  logic       go;
  logic [4:0] op;
  assign go = avs_write_i && !avs_waitrequest_o && avs_address_i == 6'h00 && avs_byteenable_i[0];
  assign op = avs_writedata_i[4:0];
  sequence s_one;   busy_o ##1 !busy_o;       endsequence
  sequence s_two;   busy_o [*2] ##1 !busy_o;  endsequence
  sequence s_three; busy_o [*3] ##1 !busy_o;  endsequence
  AST_JUMP: assert property (go && op == 5'h00 |=> s_two) else $error("jump length");
  AST_CALL: assert property (go && op == 5'h01 |=> s_three) else $error("call length");
  AST_CMPI: assert property (go && op == 5'h03 |=> s_one) else $error("compare length");
  AST_ROT: assert property (go && op inside {5'h0C, 5'h0D} |=> s_one) else $error("rotate length");
  AST_TBIT: assert property (go && op inside {5'h0E, 5'h0F} |=> s_one) else $error("bit length");
  AST_FLAG: assert property (go && op inside {5'h10, 5'h11} |=> s_one) else $error("flag length");
  AST_BRANCH: assert property (go && op inside {[5'h08:5'h0B]} |=> s_one or s_two)
    else $error("branch length");
  AST_SKIP: assert property (go && op inside {5'h02, [5'h04:5'h07]} |=> s_one or s_two or s_three)
    else $error("skip length");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low twice");
  AST_READ_ANS: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read late");
  AST_WR_STALL: assert property (busy_o && avs_write_i |-> avs_waitrequest_o) else $error("write while busy");
endmodule : bbx_exec_chk
bind bbx_exec_top bbx_exec_chk bbx_exec_chk_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

/* test/bbx_host_bfm.sv */
// Host side model: software issuing Avalon-MM transfers.
// Assumes the caller resumes right after a rising edge.
`timescale 1ns/10ps
module bbx_host_bfm (
  // Clock and answer
  input  wire logic        core_clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  // Request
  output logic      [5:0]  addr_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  be_o
);
  initial
  begin
    addr_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 32'h0;
    be_o = 4'hF;
  end
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= w;
    read_o <= !w;
    do @(posedge core_clk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    wdata_o <= ~d;
  endtask : xfer
endmodule : bbx_host_bfm

/* test/tb_top.sv */
// Self-checking bench of the execution block.
// Assumes the host model drives the register bus.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module tb_top;
  typedef struct {logic [31:0] i; logic [31:0] o; logic [7:0] s; logic [15:0] p; logic [7:0] es;
                  logic [1:0] c; logic [31:0] r;} bbx_row_t;
  localparam logic [31:0] NA = 32'hFFFFFFFF;
  logic core_clk, reset, rd_o, wr_o, wait_r, busy;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be;
  int err_total, checked;
  bbx_row_t rows [24] = '{
    '{32'h0, 32'h0, 8'hA5, 16'h1234, 8'hA5, 2'h2, NA}, '{32'h2, 32'h5A5A, 8'h0, 16'h102, 8'h0, 2'h2, NA},
    '{32'h2, 32'h1005A5A, 8'h0, 16'h103, 8'h0, 2'h3, NA}, '{32'h2, 32'h5A5B, 8'h0, 16'h101, 8'h0, 2'h1, NA},
    '{32'h200003, 32'h10, 8'h0, 16'h101, 8'h05, 2'h1, NA}, '{32'h200003, 32'h20, 8'hFF, 16'h101, 8'hD2, 2'h1, NA},
    '{32'h64, 32'hF7, 8'h0, 16'h102, 8'h0, 2'h2, NA}, '{32'hE5, 32'h1000080, 8'h0, 16'h103, 8'h0, 2'h3, NA},
    '{32'h5, 32'h80, 8'h0, 16'h101, 8'h0, 2'h1, NA}, '{32'h46, 32'h40000, 8'h0, 16'h101, 8'h0, 2'h1, NA},
    '{32'h47, 32'h40000, 8'h0, 16'h102, 8'h0, 2'h2, NA}, '{32'h508, 32'h0, 8'h01, 16'h106, 8'h01, 2'h2, NA},
    '{32'h7DE8, 32'h0, 8'h7F, 16'h101, 8'h7F, 2'h1, NA}, '{32'h7DA9, 32'h0, 8'h0, 16'hFE, 8'h0, 2'h2, NA},
    '{32'h5C9, 32'h0, 8'h40, 16'h101, 8'h40, 2'h1, NA}, '{32'h568, 32'h0, 8'h08, 16'h106, 8'h08, 2'h2, NA},
    '{32'h509, 32'h0, 8'h0, 16'h106, 8'h0, 2'h2, NA}, '{32'h50A, 32'h0, 8'h0C, 16'h106, 8'h0C, 2'h2, NA},
    '{32'h50B, 32'h0, 8'h04, 16'h106, 8'h04, 2'h2, NA}, '{32'h50B, 32'h0, 8'h0C, 16'h101, 8'h0C, 2'h1, NA},
    '{32'hC, 32'h81, 8'h01, 16'h101, 8'h09, 2'h1, 32'h103}, '{32'hD, 32'h01, 8'h0, 16'h101, 8'h0B, 2'h1, 32'h100},
    '{32'hCE, 32'h40, 8'h0, 16'h101, 8'h40, 2'h1, NA}, '{32'h2F, 32'h0, 8'h40, 16'h101, 8'h40, 2'h1, 32'h102}};
  bbx_exec_top bbx_exec_top_i (.core_clk_i(core_clk), .reset_i(reset), .avs_address_i(addr),
    .avs_read_i(rd_o), .avs_write_i(wr_o), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .busy_o(busy));
  bbx_host_bfm bbx_host_bfm_i (.core_clk_i(core_clk), .rdata_i(rdata), .wait_i(wait_r), .addr_o(addr),
    .read_o(rd_o), .write_o(wr_o), .wdata_o(wdata), .be_o(be));
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bbx_host_bfm_i.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    bbx_host_bfm_i.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic run_case(input bbx_row_t r);
    wr(bbx_pkg::off_pc, 32'h100);
    wr(bbx_pkg::off_zptr, 32'h1234);
    wr(bbx_pkg::off_status_flags_register, {24'h0, r.s});
    wr(bbx_pkg::off_operand, r.o);
    wr(bbx_pkg::off_insn, r.i);
    // Stalls until the instruction commits
    wr(bbx_pkg::off_operand, r.o);
    rd(bbx_pkg::off_pc);
    `CHK("pc", {16'h0, r.p}, q)
    rd(bbx_pkg::off_status_flags_register);
    `CHK("status_flags_register", {24'h0, r.es}, q)
    rd(bbx_pkg::off_status);
    `CHK("cycles", {(r.c != 2'h1) && (r.i[4:0] > 5'h01), 2'h0, r.c, 4'h0}, q[8:0])
    rd(bbx_pkg::off_result);
    if (r.r !== NA) `CHK("result", r.r, q[8:0])
  endtask : run_case
  task tally_and_finish;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    #500000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    err_total = 0;
    checked = 0;
    reset = 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(bbx_pkg::off_sp);
    `CHK("sp reset", 32'hFFFF, q)
    rd(bbx_pkg::off_zptr);
    `CHK("z reset", 32'h0, q)
    wr(bbx_pkg::off_status, 32'hFFFFFFFF);
    rd(bbx_pkg::off_status);
    `CHK("status ro", 32'h0, q)
    rd(6'h24);
    `CHK("unmapped", 32'h0, q)
    foreach (rows[n]) run_case(rows[n]);
    for (int s = 0; s < 8; s++)
    begin
      run_case('{32'h10 | (s << 5), 32'h0, 8'h0, 16'h101, 8'h1 << s, 2'h1, NA});
      run_case('{32'h11 | (s << 5), 32'h0, 8'hFF, 16'h101, ~(8'h1 << s), 2'h1, NA});
    end
    run_case('{32'h1, 32'h0, 8'h5A, 16'h1234, 8'h5A, 2'h3, NA});
    rd(bbx_pkg::off_sp);
    `CHK("sp", 32'hFFFD, q)
    rd(bbx_pkg::off_retaddr);
    `CHK("retaddr", 32'h101, q[15:0])
    // Reset in mid-run returns registers to reset values
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(bbx_pkg::off_sp);
    `CHK("sp mid reset", 32'hFFFF, q)
    rd(bbx_pkg::off_pc);
    `CHK("pc mid reset", 32'h0, q)
    rd(bbx_pkg::off_status);
    `CHK("status mid reset", 32'h0, q)
    tally_and_finish;
  end
endmodule : tb_top
